// ==== logic/ahsp_device.sv ====
`timescale 1ns/100ps
module ahsp_device import ahsp_pkg::*; (
  // system
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // bus
  ahsp_bus_if.device                  bus,
  // switches
  input  wire logic [ADDR_HI:ADDR_LO] base_addr_sw,
  input  wire logic [VEC_HI:VEC_LO]   vector_sw,
  // interrupt sources
  input  wire logic                   irq_enable,
  input  wire logic                   tx_irq_req,
  input  wire logic                   rx_irq_req,
  // register port
  output logic [REG_HI:REG_LO]        reg_index,
  output logic                        reg_rd_pulse,
  input  wire logic [DATA_W-1:0]      reg_rd_data,
  output logic                        reg_wr_pulse,
  output logic [1:0]                  reg_wr_be,
  output logic [DATA_W-1:0]           reg_wr_data,
  // status
  output logic                        iak_pulse,
  output logic                        iak_tx,
  output logic                        bus_init
);
  localparam int SYN_W = CTRL_W + DATA_W;
  localparam logic [SYN_W-1:0] SYN_IDLE =
    {{CTRL_W{1'b1}}, DAL_IDLE};

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_SEL   = 3'b001,
    D_OTHER = 3'b010,
    D_READ  = 3'b011,
    D_WRITE = 3'b100,
    D_IACK  = 3'b101
  } ahsp_dstate_t;

  // three-stage input filter
  logic [SYN_W-1:0] raw;
  logic [SYN_W-1:0] s1_reg;
  logic [SYN_W-1:0] s2_reg;
  logic [SYN_W-1:0] s3_reg;
  logic [SYN_W-1:0] filt_reg;

  assign raw = {bus.bus_initialize_n, bus.address_strobe_n,
                bus.data_input_strobe_n, bus.data_output_strobe_n,
                bus.write_byte_select_n, bus.io_bank_select_n,
                bus.ack_chain_in_n, bus.muxed_addr_data_lines};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= SYN_IDLE;
      s2_reg   <= SYN_IDLE;
      s3_reg   <= SYN_IDLE;
      filt_reg <= SYN_IDLE;
    end else if (clk_en) begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      // a bit moves only once stages two and three agree
      filt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) |
                  ((s2_reg ^ s3_reg) & filt_reg);
    end
  end

  logic              init_act;
  logic              sync_act;
  logic              din_act;
  logic              dout_act;
  logic              wtbt_act;
  logic              bs7_act;
  logic              iaki_act;
  logic [DATA_W-1:0] dal_in;

  assign init_act = ~filt_reg[DATA_W+6];
  assign sync_act = ~filt_reg[DATA_W+5];
  assign din_act  = ~filt_reg[DATA_W+4];
  assign dout_act = ~filt_reg[DATA_W+3];
  assign wtbt_act = ~filt_reg[DATA_W+2];
  assign bs7_act  = ~filt_reg[DATA_W+1];
  assign iaki_act = ~filt_reg[DATA_W];
  assign dal_in   = filt_reg[DATA_W-1:0];

  ahsp_dstate_t state_reg;
  ahsp_dstate_t state_next;
  logic         sync_d_reg;
  logic         out_cycle_reg;
  logic [DATA_W-1:0] addr_reg;
  logic         ie_reg;
  logic         ir_reg;
  logic         irq_n_reg;
  logic         ack_out_n_reg;
  logic         sync_rise;
  logic         addr_hit;
  logic         requesting;

  assign sync_rise  = sync_act & ~sync_d_reg;
  assign requesting = ~irq_n_reg | (state_reg == D_IACK);
  assign addr_hit   = bs7_act &&
                      dal_in[ADDR_HI:ADDR_LO] == base_addr_sw; // RULE18

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      D_IDLE: begin
        if (sync_rise) begin
          state_next = addr_hit ? D_SEL : D_OTHER; // RULE18
        end else if (din_act && !sync_act && iaki_act && requesting) begin
          state_next = D_IACK; // RULE9
        end
      end
      D_SEL: begin
        if (!sync_act) begin
          state_next = D_IDLE; // RULE7
        end else if (din_act && !out_cycle_reg) begin
          state_next = D_READ; // RULE8
        end else if (dout_act) begin
          state_next = D_WRITE; // RULE10
        end
      end
      D_OTHER: begin
        if (!sync_act) begin
          state_next = D_IDLE; // RULE7
        end
      end
      // back to selected so a modify write can follow
      D_READ: begin
        if (!din_act) begin
          state_next = D_SEL; // RULE16 RULE21
        end
      end
      D_WRITE: begin
        if (!dout_act) begin
          state_next = D_SEL; // RULE21
        end
      end
      D_IACK: begin
        if (!din_act) begin
          state_next = D_IDLE; // RULE21
        end
      end
      default: state_next = D_IDLE;
    endcase
  end

  logic enter_read;
  logic enter_write;
  logic enter_iack;

  assign enter_read  = state_next == D_READ  && state_reg != D_READ;
  assign enter_write = state_next == D_WRITE && state_reg != D_WRITE;
  assign enter_iack  = state_next == D_IACK  && state_reg != D_IACK;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= D_IDLE;
      sync_d_reg <= 1'b0;
      bus_init   <= 1'b0;
    end else if (clk_en) begin
      bus_init <= init_act;
      if (init_act) begin
        state_reg  <= D_IDLE; // RULE1
        sync_d_reg <= 1'b0;
      end else begin
        state_reg  <= state_next;
        sync_d_reg <= sync_act;
      end
    end
  end

  // address phase capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg      <= DAL_IDLE;
      out_cycle_reg <= 1'b0;
    end else if (clk_en) begin
      if (init_act) begin
        addr_reg      <= DAL_IDLE; // RULE1
        out_cycle_reg <= 1'b0;
      end else if (state_reg == D_IDLE && sync_rise) begin
        addr_reg      <= dal_in; // RULE22 RULE14
        out_cycle_reg <= wtbt_act; // RULE22 RULE11
      end
    end
  end

  assign reg_index = addr_reg[REG_HI:REG_LO];

  // register port strobes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_pulse <= 1'b0;
      reg_wr_pulse <= 1'b0;
      reg_wr_be    <= BE_WORD;
      reg_wr_data  <= DAL_IDLE;
    end else if (clk_en) begin
      reg_rd_pulse <= enter_read && !init_act; // RULE15
      reg_wr_pulse <= enter_write && !init_act; // RULE15
      if (enter_write) begin
        reg_wr_data <= dal_in; // RULE14
        if (wtbt_act) begin
          // odd address picks the high byte
          reg_wr_be <= addr_reg[BYTE_BIT] ? BE_HIGH : BE_LOW; // RULE12 RULE17
        end else begin
          reg_wr_be <= BE_WORD;
        end
      end
    end
  end

  // bus drivers follow the next state, so reply and data move together
  logic              reply_n_reg;
  logic              dal_oe_n_reg;
  logic [DATA_W-1:0] dal_out_reg;
  logic              tx_pick;

  assign tx_pick = ir_reg && tx_irq_req;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reply_n_reg  <= 1'b1;
      dal_oe_n_reg <= 1'b1;
      dal_out_reg  <= DAL_IDLE;
      iak_pulse    <= 1'b0;
      iak_tx       <= 1'b0;
    end else if (clk_en) begin
      iak_pulse <= enter_iack && !init_act;
      if (init_act) begin
        reply_n_reg  <= 1'b1; // RULE1
        dal_oe_n_reg <= 1'b1;
      end else begin
        reply_n_reg  <= !(state_next == D_READ || state_next == D_WRITE ||
                          state_next == D_IACK); // RULE13 RULE21
        dal_oe_n_reg <= !(state_next == D_READ ||
                          state_next == D_IACK); // RULE14 RULE21
      end
      if (enter_read) begin
        dal_out_reg <= reg_rd_data; // RULE8
      end else if (enter_iack) begin
        // vector goes straight out, no read path involved
        dal_out_reg                 <= DAL_IDLE; // RULE20
        dal_out_reg[VEC_HI:VEC_LO]  <= vector_sw; // RULE19
        dal_out_reg[VEC_TX_BIT]     <= tx_pick; // RULE19
        iak_tx                      <= tx_pick;
      end
    end
  end

  // interrupt request and acknowledge chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ie_reg        <= 1'b0;
      ir_reg        <= 1'b0;
      irq_n_reg     <= 1'b1;
      ack_out_n_reg <= 1'b1;
    end else if (clk_en) begin
      if (init_act) begin
        ie_reg        <= 1'b0; // RULE1
        ir_reg        <= 1'b0;
        irq_n_reg     <= 1'b1;
        ack_out_n_reg <= 1'b1;
      end else begin
        ie_reg        <= irq_enable;
        ir_reg        <= tx_irq_req | rx_irq_req;
        irq_n_reg     <= ~(ie_reg & ir_reg); // RULE2
        // one cycle late, traded for a registered output
        ack_out_n_reg <= ~(iaki_act & ~requesting); // RULE5
      end
    end
  end

  assign bus.slave_reply_n       = reply_n_reg;
  assign bus.dev_dal_oe_n        = dal_oe_n_reg;
  assign bus.dev_dal_out         = dal_out_reg;
  assign bus.interrupt_request_n = irq_n_reg;
  assign bus.ack_chain_out_n     = ack_out_n_reg;
endmodule : ahsp_device

// ==== pkg/ahsp_pkg.sv ====
// Functional notes
// RULE1: initialize line clears every unit's logic
// RULE2: request line only when enable and request
// RULE3: processor acknowledges only when priority bit clear
// RULE4: acknowledge enters first unit, ripples by position
// RULE5: requesting unit blocks acknowledge, others pass it
// RULE6: bank select marks top bank during addressing
// RULE7: transfer lasts until address strobe negates
// RULE8: input strobe with address strobe means read
// RULE9: input strobe alone means interrupt acknowledge
// RULE10: output strobe follows valid data, reply completes
// RULE11: write line at strobe lead announces output
// RULE12: write line during output strobe means byte
// RULE13: reply answers both strobes and acknowledge
// RULE14: shared lines carry address, then data
// RULE15: word read, word write, byte write cycles
// RULE16: read-modify-write keeps address strobe, then writes
// RULE17: modify write may be a byte write
// RULE18: compare address bits with base when banked
// RULE19: vector from switches, bit two selects transmitter
// RULE20: vector driven at once on acknowledge
// RULE21: reply held until strobe negates, then release
// RULE22: latch address and output flag at lead
package ahsp_pkg;
  localparam int DATA_W       = 16;
  localparam int CTRL_W       = 7;
  localparam int ADDR_LO      = 3;
  localparam int ADDR_HI      = 12;
  localparam int BANK_LO      = 12;
  localparam int VEC_LO       = 3;
  localparam int VEC_HI       = 8;
  localparam int VEC_TX_BIT   = 2;
  localparam int BYTE_BIT     = 0;
  localparam int REG_LO       = 1;
  localparam int REG_HI       = 2;
  localparam int PSW_PRIO_BIT = 7;
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_LOW  = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [DATA_W-1:0] DAL_IDLE = 16'h0000;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int ADDR_SETUP_NS    = 150;
  localparam int DESKEW_NS        = 100;
  localparam int REPLY_TIMEOUT_NS = 10000;
  localparam int INIT_PULSE_NS    = 20000;
  // least times round up, the timeout rounds down
  localparam int SETUP_CYC =
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESKEW_CYC =
    (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_CYC = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int INIT_CYC =
    (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    CYC_WORD_READ   = 3'h0,
    CYC_WORD_WRITE  = 3'h1,
    CYC_BYTE_WRITE  = 3'h2,
    CYC_RMW         = 3'h3,
    CYC_RMW_BYTE    = 3'h4
  } ahsp_cmd_t;
endpackage : ahsp_pkg

// ==== pkg/ahsp_bus_if.sv ====
`timescale 1ns/100ps
interface ahsp_bus_if import ahsp_pkg::*; ();
  logic              bus_initialize_n;
  logic              interrupt_request_n;
  logic              ack_chain_in_n;
  logic              ack_chain_out_n;
  logic              io_bank_select_n;
  logic              address_strobe_n;
  logic              data_input_strobe_n;
  logic              data_output_strobe_n;
  logic              write_byte_select_n;
  logic              slave_reply_n;
  logic [DATA_W-1:0] host_dal_out;
  logic              host_dal_oe_n;
  logic [DATA_W-1:0] dev_dal_out;
  logic              dev_dal_oe_n;
  logic [DATA_W-1:0] muxed_addr_data_lines;

  // lines float to zero when nobody drives them
  assign muxed_addr_data_lines = !dev_dal_oe_n  ? dev_dal_out  :
                                 !host_dal_oe_n ? host_dal_out :
                                 DAL_IDLE;

  modport device (
    input  bus_initialize_n, ack_chain_in_n, io_bank_select_n,
    input  address_strobe_n, data_input_strobe_n,
    input  data_output_strobe_n, write_byte_select_n,
    input  muxed_addr_data_lines,
    output interrupt_request_n, ack_chain_out_n, slave_reply_n,
    output dev_dal_out, dev_dal_oe_n
  );
  modport host (
    input  interrupt_request_n, slave_reply_n, muxed_addr_data_lines,
    output bus_initialize_n, ack_chain_in_n, io_bank_select_n,
    output address_strobe_n, data_input_strobe_n,
    output data_output_strobe_n, write_byte_select_n,
    output host_dal_out, host_dal_oe_n
  );
endinterface : ahsp_bus_if

// ==== logic/ahsp_host.sv ====
`timescale 1ns/100ps
module ahsp_host import ahsp_pkg::*; #(
  parameter int SETUP_C   = SETUP_CYC,
  parameter int DESKEW_C  = DESKEW_CYC,
  parameter int TIMEOUT_C = TIMEOUT_CYC,
  parameter int INIT_C    = INIT_CYC
) (
  // system
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // bus
  ahsp_bus_if.host               bus,
  // command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire ahsp_cmd_t         cmd_kind,
  input  wire logic [DATA_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic [7:0]        processor_status_word,
  // response
  output logic                   rsp_valid,
  output logic                   rsp_timeout,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   iak_valid,
  output logic [DATA_W-1:0]      iak_vector
);
  typedef enum logic [3:0] {
    H_INIT    = 4'b0000,
    H_IDLE    = 4'b0001,
    H_ADDR    = 4'b0010,
    H_RD      = 4'b0011,
    H_RD_END  = 4'b0100,
    H_WR_SET  = 4'b0101,
    H_WR      = 4'b0110,
    H_WR_END  = 4'b0111,
    H_IAK     = 4'b1000,
    H_IAK_END = 4'b1001
  } ahsp_hstate_t;

  localparam int SYN_W = DATA_W + 2;
  localparam logic [SYN_W-1:0] SYN_IDLE = {2'h3, DAL_IDLE};

  logic [SYN_W-1:0] s1_reg;
  logic [SYN_W-1:0] s2_reg;
  logic [SYN_W-1:0] s3_reg;
  logic [SYN_W-1:0] filt_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= SYN_IDLE;
      s2_reg   <= SYN_IDLE;
      s3_reg   <= SYN_IDLE;
      filt_reg <= SYN_IDLE;
    end else if (clk_en) begin
      s1_reg   <= {bus.interrupt_request_n, bus.slave_reply_n,
                   bus.muxed_addr_data_lines};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) |
                  ((s2_reg ^ s3_reg) & filt_reg);
    end
  end

  logic irq_act;
  logic reply_act;
  assign irq_act   = ~filt_reg[DATA_W+1];
  assign reply_act = ~filt_reg[DATA_W];

  ahsp_hstate_t      state_reg;
  ahsp_cmd_t         kind_reg;
  logic [15:0]       cnt_reg;
  logic [DATA_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              tmo;
  logic              is_read;
  logic              is_byte;
  assign tmo     = cnt_reg == 16'(TIMEOUT_C);
  assign is_read = kind_reg == CYC_WORD_READ || kind_reg == CYC_RMW ||
                   kind_reg == CYC_RMW_BYTE;
  assign is_byte = kind_reg == CYC_BYTE_WRITE || kind_reg == CYC_RMW_BYTE;
  assign cmd_ready = state_reg == H_IDLE && !irq_act;

  logic init_n_reg, iako_n_reg, bs7_n_reg, sync_n_reg;
  logic din_n_reg, dout_n_reg, wtbt_n_reg, oe_n_reg;
  logic [DATA_W-1:0] dal_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= H_INIT;
      kind_reg <= CYC_WORD_READ;
      cnt_reg <= 16'h0000;
      addr_reg <= DAL_IDLE;
      wdata_reg <= DAL_IDLE;
      init_n_reg <= 1'b0;
      iako_n_reg <= 1'b1;
      bs7_n_reg <= 1'b1;
      sync_n_reg <= 1'b1;
      din_n_reg <= 1'b1;
      dout_n_reg <= 1'b1;
      wtbt_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dal_reg <= DAL_IDLE;
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      rsp_rdata <= DAL_IDLE;
      iak_valid <= 1'b0;
      iak_vector <= DAL_IDLE;
    end else if (clk_en) begin
      cnt_reg <= cnt_reg + 16'h0001;
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      iak_valid <= 1'b0;
      case (state_reg)
        H_INIT: if (cnt_reg == 16'(INIT_C)) begin
          init_n_reg <= 1'b1; // RULE1
          state_reg <= H_IDLE;
        end
        H_IDLE: begin
          cnt_reg <= 16'h0000;
          if (irq_act && !processor_status_word[PSW_PRIO_BIT]) begin
            din_n_reg <= 1'b0; // RULE3
            iako_n_reg <= 1'b0; // RULE4
            state_reg <= H_IAK;
          end else if (cmd_valid) begin
            kind_reg <= cmd_kind;
            addr_reg <= cmd_addr;
            wdata_reg <= cmd_wdata;
            dal_reg <= cmd_addr; // RULE14
            oe_n_reg <= 1'b0;
            bs7_n_reg <= ~&cmd_addr[DATA_W-1:BANK_LO]; // RULE6
            wtbt_n_reg <= !(cmd_kind == CYC_WORD_WRITE ||
                            cmd_kind == CYC_BYTE_WRITE); // RULE11
            state_reg <= H_ADDR;
          end
        end
        H_ADDR: begin
          if (cnt_reg == 16'(SETUP_C)) begin
            sync_n_reg <= 1'b0; // RULE7
          end
          if (cnt_reg == 16'(2 * SETUP_C)) begin
            cnt_reg <= 16'h0000;
            bs7_n_reg <= 1'b1;
            wtbt_n_reg <= 1'b1;
            if (is_read) begin
              oe_n_reg <= 1'b1; // RULE14
              din_n_reg <= 1'b0; // RULE8
              state_reg <= H_RD;
            end else begin
              dal_reg <= wdata_reg;
              wtbt_n_reg <= !is_byte; // RULE12
              state_reg <= H_WR_SET;
            end
          end
        end
        H_RD: if (reply_act || tmo) begin
          rsp_rdata <= filt_reg[DATA_W-1:0];
          din_n_reg <= 1'b1;
          cnt_reg <= 16'h0000;
          state_reg <= H_RD_END;
          rsp_timeout <= tmo;
        end
        H_RD_END: if (!reply_act || tmo) begin
          cnt_reg <= 16'h0000;
          if (kind_reg == CYC_RMW || kind_reg == CYC_RMW_BYTE) begin
            dal_reg <= wdata_reg; // RULE16
            oe_n_reg <= 1'b0;
            wtbt_n_reg <= !is_byte; // RULE17
            state_reg <= H_WR_SET;
          end else begin
            sync_n_reg <= 1'b1; // RULE7
            rsp_valid <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        H_WR_SET: if (cnt_reg == 16'(DESKEW_C)) begin
          dout_n_reg <= 1'b0; // RULE10
          cnt_reg <= 16'h0000;
          state_reg <= H_WR;
        end
        H_WR: if (reply_act || tmo) begin
          dout_n_reg <= 1'b1;
          oe_n_reg <= 1'b1;
          wtbt_n_reg <= 1'b1;
          rsp_timeout <= tmo;
          cnt_reg <= 16'h0000;
          state_reg <= H_WR_END;
        end
        H_WR_END: if (!reply_act || tmo) begin
          sync_n_reg <= 1'b1; // RULE7 RULE16
          rsp_valid <= 1'b1;
          state_reg <= H_IDLE;
        end
        H_IAK: if (reply_act || tmo) begin
          iak_vector <= filt_reg[DATA_W-1:0];
          iak_valid <= !tmo;
          din_n_reg <= 1'b1;
          iako_n_reg <= 1'b1;
          cnt_reg <= 16'h0000;
          state_reg <= H_IAK_END;
        end
        H_IAK_END: if (!reply_act || tmo) begin
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign bus.bus_initialize_n     = init_n_reg;
  assign bus.ack_chain_in_n       = iako_n_reg;
  assign bus.io_bank_select_n     = bs7_n_reg;
  assign bus.address_strobe_n     = sync_n_reg;
  assign bus.data_input_strobe_n  = din_n_reg;
  assign bus.data_output_strobe_n = dout_n_reg;
  assign bus.write_byte_select_n  = wtbt_n_reg;
  assign bus.host_dal_out         = dal_reg;
  assign bus.host_dal_oe_n        = oe_n_reg;
endmodule : ahsp_host

// ==== dv/ahsp_monitor.sv ====
`timescale 1ns/100ps
module ahsp_monitor (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus
  input wire logic bus_initialize_n,
  input wire logic interrupt_request_n,
  input wire logic ack_chain_in_n,
  input wire logic ack_chain_out_n,
  input wire logic address_strobe_n,
  input wire logic data_input_strobe_n,
  input wire logic data_output_strobe_n,
  input wire logic slave_reply_n,
  input wire logic host_dal_oe_n,
  input wire logic dev_dal_oe_n
);
  wire logic strb_idle;
  assign strb_idle = data_input_strobe_n & data_output_strobe_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // the filter delays the clear
  sequence s_init_held; !bus_initialize_n [*5]; endsequence
  sequence s_released; ##[1:8] slave_reply_n; endsequence
  property p_init_clear;
    s_init_held |-> slave_reply_n && interrupt_request_n && dev_dal_oe_n;
  endproperty
  property p_reply_cause; $fell(slave_reply_n) |-> !strb_idle; endproperty
  property p_reply_release;
    $rose(strb_idle) && !slave_reply_n |-> s_released;
  endproperty
  property p_dal_release;
    $rose(slave_reply_n) |-> ##[0:1] dev_dal_oe_n;
  endproperty
  property p_read_drive;
    $fell(slave_reply_n) && !data_input_strobe_n |-> !dev_dal_oe_n;
  endproperty
  property p_write_no_drive; !data_output_strobe_n |-> dev_dal_oe_n; endproperty
  property p_no_contention; !dev_dal_oe_n |-> host_dal_oe_n; endproperty
  property p_ack_block; !interrupt_request_n ||
    !slave_reply_n && address_strobe_n |-> ack_chain_out_n; endproperty
  property p_ack_idle; $past(ack_chain_in_n,5) |-> ack_chain_out_n; endproperty
  property p_iak_cycle;
    $fell(slave_reply_n) && address_strobe_n
      |-> !ack_chain_in_n && !data_input_strobe_n;
  endproperty
  a_init_clear: assert property (p_init_clear)
    else $error("device active during initialize");
  a_reply_cause: assert property (p_reply_cause)
    else $error("reply without a strobe");
  a_reply_release: assert property (p_reply_release)
    else $error("reply held after strobe release");
  a_dal_release: assert property (p_dal_release)
    else $error("data lines kept after reply");
  a_read_drive: assert property (p_read_drive)
    else $error("reply without read data");
  a_write_no_drive: assert property (p_write_no_drive)
    else $error("device drives during write");
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive data lines");
  a_ack_block: assert property (p_ack_block)
    else $error("acknowledge passed while requesting");
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge out without acknowledge in");
  a_iak_cycle: assert property (p_iak_cycle)
    else $error("bad acknowledge reply");
endmodule : ahsp_monitor

// ==== dv/async_host_bus_slave_port_tb.sv ====
`timescale 1ns/100ps
module async_host_bus_slave_port_tb import ahsp_pkg::*; ;
  localparam logic [9:0] BASE = 10'h3a5;
  localparam logic [5:0] VEC  = 6'h2d;
  logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, to_seen;
  logic cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_timeout, iak_valid;
  logic irq_enable = 1'b0, tx_irq_req = 1'b0, rx_irq_req = 1'b0;
  logic reg_rd_pulse, reg_wr_pulse, iak_pulse;
  logic [1:0] reg_wr_be;
  logic [7:0] processor_status_word = 8'h80;
  logic [ADDR_HI:ADDR_LO] base_addr_sw = BASE;
  logic [VEC_HI:VEC_LO] vector_sw = VEC;
  logic [REG_HI:REG_LO] reg_index;
  logic [DATA_W-1:0] cmd_addr = 16'h0, cmd_wdata = 16'h0;
  logic [DATA_W-1:0] rsp_rdata, iak_vector, reg_wr_data, reg_rd_data;
  logic [DATA_W-1:0] regs [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  ahsp_cmd_t cmd_kind = CYC_WORD_READ;
  int bad_count = 0, n_compared = 0, cyc = 0, n_iak = 0;

  ahsp_bus_if bus_if ();
  ahsp_host #(.SETUP_C(1), .DESKEW_C(1), .TIMEOUT_C(40), .INIT_C(4))
    ahsp_host_i (.clk_sys, .rst_n, .clk_en, .bus(bus_if), .cmd_valid,
    .cmd_ready, .cmd_kind, .cmd_addr, .cmd_wdata, .processor_status_word,
    .rsp_valid, .rsp_timeout, .rsp_rdata, .iak_valid, .iak_vector);
  ahsp_device ahsp_device_i (.clk_sys, .rst_n, .clk_en, .bus(bus_if),
    .base_addr_sw, .vector_sw, .irq_enable, .tx_irq_req, .rx_irq_req,
    .reg_index, .reg_rd_pulse, .reg_rd_data, .reg_wr_pulse, .reg_wr_be,
    .reg_wr_data, .iak_pulse, .iak_tx(), .bus_init());
  ahsp_monitor ahsp_monitor_i (.clk_sys, .rst_n,
    .bus_initialize_n(bus_if.bus_initialize_n),
    .interrupt_request_n(bus_if.interrupt_request_n),
    .ack_chain_in_n(bus_if.ack_chain_in_n),
    .ack_chain_out_n(bus_if.ack_chain_out_n),
    .address_strobe_n(bus_if.address_strobe_n),
    .data_input_strobe_n(bus_if.data_input_strobe_n),
    .data_output_strobe_n(bus_if.data_output_strobe_n),
    .slave_reply_n(bus_if.slave_reply_n),
    .host_dal_oe_n(bus_if.host_dal_oe_n),
    .dev_dal_oe_n(bus_if.dev_dal_oe_n));

  // register file, read data valid at all times
  assign reg_rd_data = regs[reg_index];
  always @(posedge clk_sys) begin
    if (reg_wr_pulse === 1'b1)
      for (int b = 0; b < 2; b++)
        if (reg_wr_be[b]) regs[reg_index][b*8 +: 8] <= reg_wr_data[b*8 +: 8];
    // request flip-flops drop once acknowledged
    if (iak_pulse === 1'b1) begin
      tx_irq_req <= 1'b0;
      rx_irq_req <= 1'b0;
    end
  end
  always @(posedge iak_valid) n_iak++;
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  function automatic logic [15:0] ra(input logic [2:0] lo);
    return {3'h7, BASE, lo};
  endfunction : ra
  task automatic do_cmd(input ahsp_cmd_t k, input logic [15:0] a,
                        input logic [15:0] d, input logic to_exp);
    int n;
    n = 0;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    to_seen = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      #1;
      if (rsp_timeout === 1'b1) to_seen = 1'b1;
      n++;
    end
    chk1("timeout", to_exp, n < 4000 ? to_seen : !to_exp);
  endtask : do_cmd
  task give_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    int k, n;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    do_cmd(CYC_WORD_WRITE, ra(3'h2), 16'h5a3c, 1'b0);
    do_cmd(CYC_WORD_WRITE, ra(3'h4), 16'hc3e1, 1'b0);
    do_cmd(CYC_WORD_READ, ra(3'h2), 16'h0, 1'b0);
    chk16("word read", 16'h5a3c, rsp_rdata);
    do_cmd(CYC_BYTE_WRITE, ra(3'h2), 16'h00e1, 1'b0);
    do_cmd(CYC_BYTE_WRITE, ra(3'h3), 16'h7700, 1'b0);
    do_cmd(CYC_WORD_READ, ra(3'h2), 16'h0, 1'b0);
    chk16("byte merge", 16'h77e1, rsp_rdata);
    do_cmd(CYC_RMW, ra(3'h4), 16'h1234, 1'b0);
    chk16("modify old", 16'hc3e1, rsp_rdata);
    do_cmd(CYC_RMW_BYTE, ra(3'h5), 16'hab00, 1'b0);
    chk16("modify byte old", 16'h1234, rsp_rdata);
    do_cmd(CYC_WORD_READ, ra(3'h4), 16'h0, 1'b0);
    chk16("modify new", 16'hab34, rsp_rdata);
    do_cmd(CYC_WORD_READ, {3'h7, BASE ^ 10'h001, 3'h2}, 16'h0, 1'b1);
    do_cmd(CYC_WORD_WRITE, {3'h0, BASE, 3'h2}, 16'hffff, 1'b1);
    do_cmd(CYC_WORD_READ, ra(3'h2), 16'h0, 1'b0);
    chk16("refused write", 16'h77e1, rsp_rdata);
    // masked first, then released
    irq_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      processor_status_word = 8'h80;
      tx_irq_req = (i == 0);
      rx_irq_req = (i == 1);
      k = n_iak;
      repeat (60) @(negedge clk_sys);
      chk1("masked", 1'b1, n_iak == k);
      processor_status_word = 8'h00;
      n = 0;
      while (n_iak == k && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
      chk16("vector", {7'h0, VEC, i == 0, 2'h0}, iak_vector);
      repeat (20) @(negedge clk_sys);
    end
    irq_enable = 1'b0;
    tx_irq_req = 1'b1;
    k = n_iak;
    repeat (60) @(negedge clk_sys);
    chk1("disabled", 1'b1, n_iak == k);
    give_verdict();
  end
endmodule : async_host_bus_slave_port_tb
